// *** tdc_pkg.sv ***
// Constants and types for the telephone dialer control block
`default_nettype none
package tdc_pkg;
   // Notes on behaviour
   // - Dialer status bits 0, 2, 4 read live hand-free, hold and hook levels; bits 1, 3 the states
   // - Auto-select bit 5 set: line follows combination; clear: line low unless line control is active
   // - Bit 6 drives dial-pulse open drain: one floats, zero pulls low
   // - Bit 7 drives speech mute open drain: one floats, zero pulls low
   // - Combination breaks the line only on-hook with no hand-free or hold
   // - On-hook with hold active: hold falling edge raises no dialer irq
   // - Dialer state machine runs in normal, green, sleep; frozen in idle
   // - Line control register: bit 7 enable, bits 6..0 read zero
   // - Line control source: timer in normal/green, wake or timer in
   //      sleep, wake in idle
   // - Active enabled line-control source drives line make output high
   // - Writing zero to line control enable ends it; line output low unless auto-select and combination hold it
   // - Seconds timer register: bit 5 enable, bits 6 and 4..0 read zero
   // - Enabled timer times out every 1000 ms, setting request and flag
   // - Seconds timer interrupt uses vector 14h
   // - Service clears the request only; software clears time-out flag
   // - A left-set time-out flag does not block the next interrupt
   // - Hook rising edge: on-hook; falling: off-hook, clear both; irq
   // - Hand-free pulse clears hold, toggles hand-free, raises irq 18h
   // - Hold low pulse clears hand-free, toggles hold, irq; line made

   // Register indices; byte address is four times the index
   localparam int TDC_AW = 6;
   localparam logic [TDC_AW-1:0] TDC_IDX_DIALER = 6'h16;
   localparam logic [TDC_AW-1:0] TDC_IDX_LINE = 6'h22;
   localparam logic [TDC_AW-1:0] TDC_IDX_SEC = 6'h24;

   // Field positions
   localparam int TDC_B_HFR = 0;
   localparam int TDC_B_HFS = 1;
   localparam int TDC_B_HLR = 2;
   localparam int TDC_B_HLS = 3;
   localparam int TDC_B_HOOK = 4;
   localparam int TDC_B_AUTO = 5;
   localparam int TDC_B_DNP = 6;
   localparam int TDC_B_MUTE = 7;
   localparam int TDC_B_LCEN = 7;
   localparam int TDC_B_SECEN = 5;
   localparam int TDC_B_SECTO = 7;

   // Pin order inside the synchroniser vector
   localparam int TDC_PIN_COUNT = 3;
   localparam int TDC_PIN_HOOK = 0;
   localparam int TDC_PIN_HFR = 1;
   localparam int TDC_PIN_HLR = 2;

   // Reset values
   localparam logic TDC_RST_AUTO = 1'b1;
   localparam logic TDC_RST_DNP = 1'b1;
   localparam logic TDC_RST_MUTE = 1'b1;

   // Operating modes
   localparam logic [1:0] TDC_MODE_NORMAL = 2'h0;
   localparam logic [1:0] TDC_MODE_GREEN = 2'h1;
   localparam logic [1:0] TDC_MODE_SLEEP = 2'h2;
   localparam logic [1:0] TDC_MODE_IDLE = 2'h3;

   // Interrupt vectors
   localparam logic [7:0] TDC_VEC_SEC = 8'h14;
   localparam logic [7:0] TDC_VEC_DIAL = 8'h18;

   // Timing
   localparam int TDC_TIMEOUT_MS = 1000;
   localparam int TDC_CLK_KHZ = 50000;
   localparam int TDC_SEC_CYCLES = TDC_TIMEOUT_MS * TDC_CLK_KHZ;

   typedef enum logic [1:0]
   {
      TDC_ON_HOOK = 2'b01,
      TDC_OFF_HOOK = 2'b10
   } tdc_hook_type;
endpackage
`default_nettype wire

// *** tdc_sync.sv ***
// Pin synchroniser with edge detection for the dialer inputs
`default_nettype none
module tdc_sync
   #(
   parameter int WIDTH = 3
   )
   (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall,
   output logic ready
   );
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;
   logic [2:0] fill;

   // Meta feeds only the second stage
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta <= '0;
         level <= '0;
         prev <= '0;
      end
      else
      begin
         meta <= async_in;
         level <= meta;
         prev <= level;
      end
   end

   // Edges are held off until all stages carry real pin data
   always_ff @(posedge clk)
   begin
      if (rst)
         fill <= 3'h0;
      else
         fill <= {fill[1:0], 1'b1};
   end

   assign ready = fill[2];
   assign rise = level & ~prev & {WIDTH{ready}};
   assign fall = ~level & prev & {WIDTH{ready}};
endmodule
`default_nettype wire

// *** tdc_dialer.sv ***
// Telephone dialer control: pins, line control, seconds timer, registers
`default_nettype none
module tdc_dialer
   import tdc_pkg::*;
   #(
   parameter int unsigned SEC_CYCLES = TDC_SEC_CYCLES
   )
   (
   input wire logic clk,
   input wire logic rst,
   input wire logic [TDC_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic hook_switch_in,
   input wire logic handsfree_request_in,
   input wire logic hold_request_in,
   input wire logic [1:0] op_mode,
   input wire logic port_a_wakeup,
   input wire logic seconds_irq_ack,
   input wire logic dialer_irq_ack,
   output logic line_make_out,
   output logic handsfree_state_out,
   output logic hold_state_out,
   input wire logic dial_pulse_out_in,
   output logic dial_pulse_out_o,
   output logic dial_pulse_out_oe,
   input wire logic speech_mute_out_in,
   output logic speech_mute_out_o,
   output logic speech_mute_out_oe,
   output logic seconds_irq_request,
   output logic [7:0] seconds_irq_vector,
   output logic dialer_irq_request,
   output logic [7:0] dialer_irq_vector
   );
   localparam int CW = $clog2(SEC_CYCLES);

   logic [TDC_PIN_COUNT-1:0] pin_lvl;
   logic [TDC_PIN_COUNT-1:0] pin_rise;
   logic [TDC_PIN_COUNT-1:0] pin_fall;
   logic sync_ready;
   logic acc_req;
   logic wr_go;
   logic [7:0] wd;
   logic [7:0] rd_byte;
   logic line_out_auto_sel;
   logic dial_pulse_sw_level;
   logic mute_sw_level;
   logic line_ctl_enable;
   logic line_ctl_active;
   logic lc_src;
   logic seconds_timer_enable;
   logic seconds_timeout_flag;
   logic [CW-1:0] sec_count;
   logic sec_tick;
   tdc_hook_type dstate;
   tdc_hook_type next_dstate;
   logic on_hook;
   logic line_combo;
   logic dial_active;
   logic hold_ok;
   logic hold_silent;
   logic dial_evt;
   logic next_line_make;

   function automatic logic wr_to(input logic go,
      input logic [TDC_AW-1:0] a, input logic [TDC_AW-1:0] idx);
      wr_to = go && (a == idx);
   endfunction

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   tdc_sync #(.WIDTH(TDC_PIN_COUNT)) u_sync
   (
      .clk(clk),
      .rst(rst),
      .async_in({hold_request_in, handsfree_request_in, hook_switch_in}),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall),
      .ready(sync_ready)
   );

   // ------------------------------------------------------------------
   // Avalon slave: one wait cycle, then the access completes
   // ------------------------------------------------------------------
   assign acc_req = (avs_read || avs_write) && avs_waitrequest;
   assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign wd = avs_writedata[7:0];

   always_ff @(posedge clk)
   begin
      if (rst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !acc_req;
   end

   always_comb
   begin
      rd_byte = 8'h00;
      if (avs_address == TDC_IDX_DIALER)
      begin
         rd_byte[TDC_B_HFR] = pin_lvl[TDC_PIN_HFR];
         rd_byte[TDC_B_HFS] = handsfree_state_out;
         rd_byte[TDC_B_HLR] = pin_lvl[TDC_PIN_HLR];
         rd_byte[TDC_B_HLS] = hold_state_out;
         rd_byte[TDC_B_HOOK] = pin_lvl[TDC_PIN_HOOK];
         rd_byte[TDC_B_AUTO] = line_out_auto_sel;
         rd_byte[TDC_B_DNP] = dial_pulse_sw_level;
         rd_byte[TDC_B_MUTE] = mute_sw_level;
      end
      else if (avs_address == TDC_IDX_LINE)
         rd_byte[TDC_B_LCEN] = line_ctl_enable;
      else if (avs_address == TDC_IDX_SEC)
      begin
         rd_byte[TDC_B_SECEN] = seconds_timer_enable;
         rd_byte[TDC_B_SECTO] = seconds_timeout_flag;
      end
   end

   // Unmapped addresses read zero
   always_ff @(posedge clk)
   begin
      if (rst)
         avs_readdata <= 32'h00000000;
      else if (acc_req && avs_read)
         avs_readdata <= {24'h000000, rd_byte};
   end

   // ------------------------------------------------------------------
   // Software control bits
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         line_out_auto_sel <= TDC_RST_AUTO;
         dial_pulse_sw_level <= TDC_RST_DNP;
         mute_sw_level <= TDC_RST_MUTE;
         line_ctl_enable <= 1'b0;
         seconds_timer_enable <= 1'b0;
      end
      else
      begin
         if (wr_to(wr_go, avs_address, TDC_IDX_DIALER))
         begin
            line_out_auto_sel <= wd[TDC_B_AUTO];
            dial_pulse_sw_level <= wd[TDC_B_DNP];
            mute_sw_level <= wd[TDC_B_MUTE];
         end
         if (wr_to(wr_go, avs_address, TDC_IDX_LINE))
            line_ctl_enable <= wd[TDC_B_LCEN];
         if (wr_to(wr_go, avs_address, TDC_IDX_SEC))
            seconds_timer_enable <= wd[TDC_B_SECEN];
      end
   end

   // Open-drain pins only ever pull low
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dial_pulse_out_o <= 1'b0;
         dial_pulse_out_oe <= 1'b0;
         speech_mute_out_o <= 1'b0;
         speech_mute_out_oe <= 1'b0;
      end
      else
      begin
         dial_pulse_out_o <= 1'b0;
         dial_pulse_out_oe <= !dial_pulse_sw_level;
         speech_mute_out_o <= 1'b0;
         speech_mute_out_oe <= !mute_sw_level;
      end
   end

   // ------------------------------------------------------------------
   // Seconds timer
   // ------------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst || !seconds_timer_enable)
      begin
         sec_count <= '0;
         sec_tick <= 1'b0;
      end
      else if (sec_count == CW'(SEC_CYCLES - 1))
      begin
         sec_count <= '0;
         sec_tick <= 1'b1;
      end
      else
      begin
         sec_count <= sec_count + 1'b1;
         sec_tick <= 1'b0;
      end
   end

   // Set wins over both clears; request ignores the flag's state
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         seconds_timeout_flag <= 1'b0;
         seconds_irq_request <= 1'b0;
         seconds_irq_vector <= TDC_VEC_SEC;
      end
      else
      begin
         seconds_irq_vector <= TDC_VEC_SEC;
         if (sec_tick)
            seconds_timeout_flag <= 1'b1;
         else if (wr_to(wr_go, avs_address, TDC_IDX_SEC))
            seconds_timeout_flag <= wd[TDC_B_SECTO];
         if (sec_tick)
            seconds_irq_request <= 1'b1;
         else if (seconds_irq_ack)
            seconds_irq_request <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Line control
   // ------------------------------------------------------------------
   always_comb
   begin
      if (op_mode == TDC_MODE_NORMAL || op_mode == TDC_MODE_GREEN)
         lc_src = sec_tick;
      else if (op_mode == TDC_MODE_SLEEP)
         lc_src = port_a_wakeup || sec_tick;
      else
         lc_src = port_a_wakeup;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         line_ctl_active <= 1'b0;
      else if (wr_to(wr_go, avs_address, TDC_IDX_LINE) && !wd[TDC_B_LCEN])
         line_ctl_active <= 1'b0;
      else if (line_ctl_enable && lc_src)
         line_ctl_active <= 1'b1;
   end

   // ------------------------------------------------------------------
   // Dialer state machine
   // ------------------------------------------------------------------
   assign on_hook = (dstate == TDC_ON_HOOK);
   assign line_combo = !(on_hook && !handsfree_state_out
      && !hold_state_out);
   assign dial_active = (op_mode != TDC_MODE_IDLE) && sync_ready;
   assign hold_ok = pin_fall[TDC_PIN_HLR] && line_combo;
   assign hold_silent = on_hook && hold_state_out;
   assign dial_evt = dial_active && (pin_rise[TDC_PIN_HOOK]
      || pin_fall[TDC_PIN_HOOK] || pin_rise[TDC_PIN_HFR]
      || (hold_ok && !hold_silent));

   always_comb
   begin
      next_dstate = dstate;
      case (dstate)
         TDC_ON_HOOK:
            if (pin_fall[TDC_PIN_HOOK])
               next_dstate = TDC_OFF_HOOK;
         TDC_OFF_HOOK:
            if (pin_rise[TDC_PIN_HOOK])
               next_dstate = TDC_ON_HOOK;
         default:
            next_dstate = TDC_ON_HOOK;
      endcase
   end

   // Hook state is copied from the pin until the synchroniser is filled
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dstate <= TDC_ON_HOOK;
         handsfree_state_out <= 1'b0;
         hold_state_out <= 1'b0;
      end
      else if (!sync_ready)
         dstate <= pin_lvl[TDC_PIN_HOOK] ? TDC_ON_HOOK : TDC_OFF_HOOK;
      else if (dial_active)
      begin
         dstate <= next_dstate;
         if (pin_fall[TDC_PIN_HOOK])
         begin
            handsfree_state_out <= 1'b0;
            hold_state_out <= 1'b0;
         end
         else if (!pin_rise[TDC_PIN_HOOK] && pin_rise[TDC_PIN_HFR])
         begin
            hold_state_out <= 1'b0;
            handsfree_state_out <= !handsfree_state_out;
         end
         else if (!pin_rise[TDC_PIN_HOOK] && hold_ok)
         begin
            handsfree_state_out <= 1'b0;
            hold_state_out <= !hold_state_out;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dialer_irq_request <= 1'b0;
         dialer_irq_vector <= TDC_VEC_DIAL;
      end
      else
      begin
         dialer_irq_vector <= TDC_VEC_DIAL;
         if (dial_evt)
            dialer_irq_request <= 1'b1;
         else if (dialer_irq_ack)
            dialer_irq_request <= 1'b0;
      end
   end

   assign next_line_make = line_ctl_active
      || (line_out_auto_sel && line_combo);

   always_ff @(posedge clk)
   begin
      if (rst)
         line_make_out <= 1'b0;
      else
         line_make_out <= next_line_make;
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_status_read;
      avs_read && avs_waitrequest && avs_address == TDC_IDX_DIALER
         |=> !avs_waitrequest
         && avs_readdata[TDC_B_HOOK] == $past(pin_lvl[TDC_PIN_HOOK]);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read lost hook level");

   property p_auto_off;
      !line_out_auto_sel && !line_ctl_active |=> !line_make_out;
   endproperty
   a_auto_off: assert property (p_auto_off)
      else $error("line high with auto select clear");

   property p_dial_pulse;
      wr_to(wr_go, avs_address, TDC_IDX_DIALER) && !wd[TDC_B_DNP]
         |-> ##2 dial_pulse_out_oe;
   endproperty
   a_dial_pulse: assert property (p_dial_pulse)
      else $error("dial pulse not pulled low");

   property p_mute;
      wr_to(wr_go, avs_address, TDC_IDX_DIALER) && wd[TDC_B_MUTE]
         |-> ##2 !speech_mute_out_oe;
   endproperty
   a_mute: assert property (p_mute)
      else $error("mute not released");

   property p_break;
      line_out_auto_sel && !line_ctl_active && on_hook
         && !handsfree_state_out && !hold_state_out |=> !line_make_out;
   endproperty
   a_break: assert property (p_break)
      else $error("line not broken on-hook");

   property p_hold_silent;
      hold_silent && pin_fall[TDC_PIN_HLR] && !pin_rise[TDC_PIN_HOOK]
         && !pin_fall[TDC_PIN_HOOK] && !pin_rise[TDC_PIN_HFR] |-> !dial_evt;
   endproperty
   a_hold_silent: assert property (p_hold_silent)
      else $error("hold edge raised irq on-hook");

   property p_idle;
      op_mode == TDC_MODE_IDLE |=> $stable(handsfree_state_out)
         && $stable(hold_state_out);
   endproperty
   a_idle: assert property (p_idle)
      else $error("dialer changed in idle");

   property p_line_ctl;
      line_ctl_enable && sec_tick && op_mode == TDC_MODE_NORMAL
         && !wr_to(wr_go, avs_address, TDC_IDX_LINE)
         |=> line_ctl_active ##1 line_make_out;
   endproperty
   a_line_ctl: assert property (p_line_ctl)
      else $error("line control did not make line");

   property p_line_end;
      wr_to(wr_go, avs_address, TDC_IDX_LINE) && !wd[TDC_B_LCEN]
         |=> !line_ctl_active;
   endproperty
   a_line_end: assert property (p_line_end)
      else $error("line control not ended");

   property p_tick;
      sec_tick |=> seconds_irq_request && seconds_timeout_flag;
   endproperty
   a_tick: assert property (p_tick)
      else $error("time-out did not set flags");

   property p_hook_fall;
      dial_active && pin_fall[TDC_PIN_HOOK] |=> !handsfree_state_out
         && !hold_state_out && dialer_irq_request && !on_hook;
   endproperty
   a_hook_fall: assert property (p_hook_fall)
      else $error("off-hook edge mishandled");

   property p_handsfree;
      dial_active && pin_rise[TDC_PIN_HFR] && !pin_rise[TDC_PIN_HOOK]
         && !pin_fall[TDC_PIN_HOOK] |=> !hold_state_out
         && handsfree_state_out != $past(handsfree_state_out);
   endproperty
   a_handsfree: assert property (p_handsfree)
      else $error("hand-free pulse mishandled");

   c_tick: cover property (sec_tick ##1 seconds_irq_request);
   c_offhook: cover property (pin_fall[TDC_PIN_HOOK] && dial_active);
   c_hold: cover property (hold_ok && dial_active ##1 hold_state_out);
endmodule
`default_nettype wire

// *** tdc_line_model.sv ***
// Far-side model: hook switch, handset keys and line pull-ups
`default_nettype none
module tdc_line_model
   (
   input wire logic clk,
   output logic hook_switch_in,
   output logic handsfree_request_in,
   output logic hold_request_in,
   input wire logic dial_pulse_out_o,
   input wire logic dial_pulse_out_oe,
   input wire logic speech_mute_out_o,
   input wire logic speech_mute_out_oe,
   output logic dp_level,
   output logic mute_level
   );
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // Idle levels: on-hook, keys released
   // ----------------------------------------
   initial
   begin
      hook_switch_in = 1'b1;
      handsfree_request_in = 1'b0;
      hold_request_in = 1'b1;
   end

   // Pulled-up lines float high when released, never hold a stale value
   assign dp_level = dial_pulse_out_oe ? dial_pulse_out_o : 1'b1;
   assign mute_level = speech_mute_out_oe ? speech_mute_out_o : 1'b1;

   // ----------------------------------------
   // Key and switch actions
   // ----------------------------------------
   task automatic set_hook(input logic v);
      @(posedge clk);
      hook_switch_in <= v;
   endtask

   // Held n cycles; n of 4 or more outlasts the synchroniser
   task automatic press_hf(input int n);
      @(posedge clk);
      handsfree_request_in <= 1'b1;
      repeat (n) @(posedge clk);
      handsfree_request_in <= 1'b0;
   endtask

   task automatic press_hold(input int n);
      @(posedge clk);
      hold_request_in <= 1'b0;
      repeat (n) @(posedge clk);
      hold_request_in <= 1'b1;
   endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the telephone dialer control block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tdc_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam int SEC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [TDC_AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic hook_switch_in, handsfree_request_in, hold_request_in;
   logic [1:0] op_mode = 2'h0;
   logic port_a_wakeup = 1'b0;
   logic seconds_irq_ack = 1'b0;
   logic dialer_irq_ack = 1'b0;
   logic line_make_out, handsfree_state_out, hold_state_out;
   logic dial_pulse_out_o, dial_pulse_out_oe;
   logic speech_mute_out_o, speech_mute_out_oe;
   logic seconds_irq_request, dialer_irq_request;
   logic [7:0] seconds_irq_vector, dialer_irq_vector;
   logic dp_level, mute_level, sec_q = 1'b0;
   logic [31:0] q;
   int mismatches = 0;
   int n_checks = 0;
   int cyc_n = 0;
   int rise1 = 0;
   int rise2 = 0;

   tdc_dialer #(.SEC_CYCLES(SEC)) dut
   (
      .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .hook_switch_in,
      .handsfree_request_in, .hold_request_in, .op_mode, .port_a_wakeup,
      .seconds_irq_ack, .dialer_irq_ack, .line_make_out,
      .handsfree_state_out, .hold_state_out,
      .dial_pulse_out_in(dp_level), .dial_pulse_out_o, .dial_pulse_out_oe,
      .speech_mute_out_in(mute_level), .speech_mute_out_o,
      .speech_mute_out_oe, .seconds_irq_request, .seconds_irq_vector,
      .dialer_irq_request, .dialer_irq_vector
   );

   tdc_line_model line
   (
      .clk, .hook_switch_in, .handsfree_request_in, .hold_request_in,
      .dial_pulse_out_o, .dial_pulse_out_oe, .speech_mute_out_o,
      .speech_mute_out_oe, .dp_level, .mute_level
   );

   initial
      forever #10 clk = ~clk;

   // Edge stamps of the timer request, for the period check
   always @(posedge clk)
   begin
      cyc_n <= cyc_n + 1;
      sec_q <= seconds_irq_request;
      if (seconds_irq_request && !sec_q)
      begin
         rise1 <= rise2;
         rise2 <= cyc_n;
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until waitrequest is sampled low at an edge
   task automatic bus(input logic w, input logic [5:0] a,
      input logic [7:0] d, input logic [3:0] b, output logic [31:0] r);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= b;
      avs_read <= !w;
      avs_write <= w;
      // Only the watchdog ends a wait that never gets an answer
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge clk);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'h1, q);
   endtask

   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00, 4'h1, q);
      chk(q, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic ack(input logic sec);
      @(posedge clk);
      seconds_irq_ack <= sec;
      dialer_irq_ack <= !sec;
      @(posedge clk);
      seconds_irq_ack <= 1'b0;
      dialer_irq_ack <= 1'b0;
   endtask

   task automatic wait_sec;
      while (seconds_irq_request !== 1'b1)
         @(negedge clk);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      cyc(8);
      chk(line_make_out, 1'b0);
      rd_chk(TDC_IDX_DIALER, 32'hf4);
      rd_chk(TDC_IDX_LINE, 32'h00);
      rd_chk(TDC_IDX_SEC, 32'h00);
      rd_chk(6'h01, 32'h00);
      wr(TDC_IDX_DIALER, 8'h3f);
      cyc(2);
      chk({dp_level, mute_level}, 2'b00);
      rd_chk(TDC_IDX_DIALER, 32'h34);
      // Lane 0 disabled: write must not land
      bus(1'b1, TDC_IDX_DIALER, 8'he0, 4'h0, q);
      cyc(2);
      chk({dp_level, mute_level}, 2'b00);
      wr(TDC_IDX_DIALER, 8'he0);
      cyc(2);
      chk({dp_level, mute_level}, 2'b11);
      line.press_hf(4);
      cyc(8);
      chk({handsfree_state_out, hold_state_out, dialer_irq_request},
          3'b101);
      chk(dialer_irq_vector, 8'h18);
      chk(line_make_out, 1'b1);
      rd_chk(TDC_IDX_DIALER, 32'hf6);
      ack(1'b0);
      cyc(2);
      chk(dialer_irq_request, 1'b0);
      line.press_hold(4);
      cyc(8);
      chk({handsfree_state_out, hold_state_out, dialer_irq_request},
          3'b011);
      chk(line_make_out, 1'b1);
      rd_chk(TDC_IDX_DIALER, 32'hfc);
      ack(1'b0);
      line.press_hold(4);
      cyc(8);
      chk({hold_state_out, dialer_irq_request, line_make_out}, 3'b000);
      line.press_hf(4);
      cyc(8);
      ack(1'b0);
      line.set_hook(1'b0);
      cyc(8);
      chk({handsfree_state_out, dialer_irq_request, line_make_out},
          3'b011);
      ack(1'b0);
      wr(TDC_IDX_DIALER, 8'hc0);
      cyc(3);
      chk(line_make_out, 1'b0);
      wr(TDC_IDX_DIALER, 8'he0);
      cyc(3);
      chk(line_make_out, 1'b1);
      @(posedge clk);
      op_mode <= TDC_MODE_IDLE;
      line.press_hf(4);
      cyc(8);
      chk({handsfree_state_out, dialer_irq_request}, 2'b00);
      @(posedge clk);
      op_mode <= TDC_MODE_NORMAL;
      line.set_hook(1'b1);
      cyc(8);
      chk({dialer_irq_request, line_make_out}, 2'b10);
      ack(1'b0);
      wr(TDC_IDX_LINE, 8'hff);
      rd_chk(TDC_IDX_LINE, 32'h80);
      wr(TDC_IDX_SEC, 8'h7f);
      rd_chk(TDC_IDX_SEC, 32'h20);
      wait_sec;
      cyc(3);
      chk(line_make_out, 1'b1);
      chk(seconds_irq_vector, 8'h14);
      rd_chk(TDC_IDX_SEC, 32'ha0);
      ack(1'b1);
      cyc(1);
      chk(seconds_irq_request, 1'b0);
      rd_chk(TDC_IDX_SEC, 32'ha0);
      wait_sec;
      cyc(2);
      chk(seconds_irq_request, 1'b1);
      chk(rise2 - rise1, SEC);
      wr(TDC_IDX_LINE, 8'h00);
      cyc(3);
      chk(line_make_out, 1'b0);
      wr(TDC_IDX_SEC, 8'h00);
      ack(1'b1);
      rd_chk(TDC_IDX_SEC, 32'h00);
      // Wake-up only counts in sleep and idle while the timer is off
      for (int m = 0; m < 4; m++)
      begin
         wr(TDC_IDX_LINE, 8'h80);
         @(posedge clk);
         op_mode <= 2'(m);
         port_a_wakeup <= 1'b1;
         @(posedge clk);
         port_a_wakeup <= 1'b0;
         cyc(4);
         chk(line_make_out, 1'(m >= 2));
         wr(TDC_IDX_LINE, 8'h00);
         cyc(3);
         chk(line_make_out, 1'b0);
      end
      end_of_test;
   end

   initial
   begin
      repeat (6000) @(posedge clk);
      mismatches++;
      end_of_test;
   end
endmodule
`default_nettype wire
